// ==== logic/xmp_pkg.sv ====
// Constants and carrier types for the external memory port
package xmp_pkg;

  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam logic [7:0] XMP_PAGE_ADDR = 8'hAA;
  localparam logic [7:0] XMP_CFG_ADDR = 8'hC7;
  localparam logic [7:0] XMP_PAGE_RESET = 8'h00;
  localparam logic [7:0] XMP_CFG_RESET = 8'h03;
  localparam logic [7:0] XMP_CFG_WMASK = 8'h1F;

  // ****************************************
  // Configuration fields
  // ****************************************
  localparam int XMP_CFG_MUX_BIT = 4;
  localparam int XMP_CFG_MODE_LSB = 2;
  localparam int XMP_CFG_ALE_LSB = 0;

  localparam logic [1:0] XMP_MODE_ONCHIP = 2'h0;
  localparam logic [1:0] XMP_MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] XMP_MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] XMP_MODE_OFFCHIP = 2'h3;

  localparam logic [15:0] XMP_ONCHIP_SIZE = 16'h0400;

  // ****************************************
  // Timing counts in system clock cycles
  // ****************************************
  localparam logic [2:0] XMP_SETUP_CYC = 3'h1;
  localparam logic [2:0] XMP_STROBE_CYC = 3'h4;
  localparam logic [2:0] XMP_HOLD_CYC = 3'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [6:0] {
    XMP_ST_IDLE   = 7'h01,
    XMP_ST_ONCHIP = 7'h02,
    XMP_ST_SETUP  = 7'h04,
    XMP_ST_ALE_HI = 7'h08,
    XMP_ST_ALE_LO = 7'h10,
    XMP_ST_STROBE = 7'h20,
    XMP_ST_HOLD   = 7'h40
  } xmp_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xmp_sfr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] data_pointer;
    logic [7:0] ri;
    logic [7:0] wdata;
  } xmp_req_t;

  typedef struct packed {
    logic [7:0] ad_out;
    logic [7:0] ad_oe;
    logic [7:0] alo_out;
    logic alo_oe;
    logic [7:0] ahi_out;
    logic ahi_oe;
    logic ale_out;
    logic ale_oe;
    logic rd_n_out;
    logic rd_n_oe;
    logic wr_n_out;
    logic wr_n_oe;
  } xmp_pins_t;

endpackage

// ==== logic/xmp_port.sv ====
// External data memory port: registers, routing and pin sequencing
//
// How it works
// - Pins claimed only during off-chip moves
// - Input pins undriven during off-chip reads, except while they carry the multiplexed address
// - Pin output mode left to port registers
// - Read and write strobes outside crossbar
// - Multiplexed or dedicated address and data pins
// - Page register supplies upper address byte
// - Page N covers N*256 to N*256+255
// - Config bit 4 selects pin arrangement
// - Mode 00 aliases everything on-chip
// - Mode 01 splits; port latches give high
// - Mode 10 splits; page gives high byte
// - Mode 11 sends everything off-chip
// - Config bits 1-0 set address latch pulse width
// - Config bits 7-5 read zero
// - Short form takes low byte from index
// - High pins undriven for short access outside mode 10
`timescale 1ns/10ps

module xmp_port
  import xmp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire xmp_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  input wire xmp_req_t req,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic onchip_sel,
  output logic onchip_write,
  output logic [9:0] onchip_addr,
  output logic [7:0] onchip_wdata,
  input wire logic [7:0] onchip_rdata,
  input wire logic [7:0] ad_in,
  output xmp_pins_t pins
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    xmp_state_t fsm;
    logic [2:0] cnt;
    logic [7:0] page;
    logic [7:0] cfg;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic hi_drive;
    logic [7:0] rdata;
    logic [7:0] sfr_rdata;
    logic done;
    logic onchip_sel;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    xmp_pins_t pins;
  } xmp_regs_t;

  xmp_regs_t r;
  xmp_regs_t next_r;

  // Decides whether an effective address leaves the chip
  function automatic logic xmp_is_offchip(input logic [1:0] mode,
                                          input logic [15:0] eff);
    logic res;
    res = 1'b0;
    unique case (mode)
      XMP_MODE_ONCHIP: res = 1'b0;
      XMP_MODE_OFFCHIP: res = 1'b1;
      // split, high byte left to port latches
      XMP_MODE_SPLIT_NOBANK: res = (eff >= XMP_ONCHIP_SIZE);
      // split, high byte from page register
      XMP_MODE_SPLIT_BANK: res = (eff >= XMP_ONCHIP_SIZE);
    endcase
    return res;
  endfunction

  // Idle pin set: nothing claimed, strobes inactive
  function automatic xmp_pins_t xmp_idle_pins();
    xmp_pins_t p;
    p = '0;
    p.rd_n_out = 1'b1;
    p.wr_n_out = 1'b1;
    return p;
  endfunction

  // Register bus hit on one address
  function automatic logic xmp_hit(input xmp_sfr_t s,
                                   input logic [7:0] a);
    return s.addr == a;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0] mode;
    logic mux;
    logic [2:0] ale_w;
    logic [15:0] eff;
    logic claim;
    mode = r.cfg[XMP_CFG_MODE_LSB +: 2];
    mux = ~r.cfg[XMP_CFG_MUX_BIT];
    ale_w = {1'b0, r.cfg[XMP_CFG_ALE_LSB +: 2]};
    eff = req.wide ? req.data_pointer : {r.page, req.ri};
    claim = 1'b0;

    next_r = r;
    next_r.done = 1'b0;
    next_r.onchip_sel = 1'b0;
    // Data pads pass three stages
    next_r.sync1 = ad_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;

    // Register writes
    if (sfr.wr && xmp_hit(sfr, XMP_PAGE_ADDR)) begin
      next_r.page = sfr.wdata;
    end
    if (sfr.wr && xmp_hit(sfr, XMP_CFG_ADDR)) begin
      next_r.cfg = sfr.wdata & XMP_CFG_WMASK;
    end

    // Register reads
    next_r.sfr_rdata = 8'h00;
    if (sfr.rd) begin
      if (xmp_hit(sfr, XMP_PAGE_ADDR)) begin
        next_r.sfr_rdata = r.page;
      end else if (xmp_hit(sfr, XMP_CFG_ADDR)) begin
        next_r.sfr_rdata = r.cfg & XMP_CFG_WMASK;
      end
    end

    // Sequencer
    unique case (r.fsm)
      XMP_ST_IDLE: begin
        if (req.valid) begin
          next_r.write = req.write;
          next_r.wdata = req.wdata;
          next_r.addr = eff;
          // high byte driven only if defined
          next_r.hi_drive = req.wide || mode == XMP_MODE_SPLIT_BANK;
          if (!xmp_is_offchip(mode, eff)) begin
            next_r.fsm = XMP_ST_ONCHIP;
            next_r.onchip_sel = 1'b1;
          end else if (mux) begin
            next_r.fsm = XMP_ST_ALE_HI;
            next_r.cnt = ale_w;
          end else begin
            next_r.fsm = XMP_ST_SETUP;
            next_r.cnt = XMP_SETUP_CYC - 3'h1;
          end
        end
      end
      XMP_ST_ONCHIP: begin
        if (!r.write) begin
          next_r.rdata = onchip_rdata;
        end
        next_r.done = 1'b1;
        next_r.fsm = XMP_ST_IDLE;
      end
      XMP_ST_SETUP: begin
        next_r.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          next_r.fsm = XMP_ST_STROBE;
          next_r.cnt = XMP_STROBE_CYC - 3'h1;
        end
      end
      XMP_ST_ALE_HI: begin
        next_r.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          next_r.fsm = XMP_ST_ALE_LO;
          next_r.cnt = ale_w;
        end
      end
      XMP_ST_ALE_LO: begin
        next_r.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          next_r.fsm = XMP_ST_STROBE;
          next_r.cnt = XMP_STROBE_CYC - 3'h1;
        end
      end
      XMP_ST_STROBE: begin
        next_r.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          // Pads reach stage three by the last strobe cycle
          // Settled bus value only
          if (!r.write && r.sync2 == r.sync3) begin
            next_r.rdata = r.sync3;
          end
          next_r.fsm = XMP_ST_HOLD;
          next_r.cnt = XMP_HOLD_CYC - 3'h1;
        end
      end
      XMP_ST_HOLD: begin
        next_r.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          next_r.done = 1'b1;
          next_r.fsm = XMP_ST_IDLE;
        end
      end
      default: begin
        next_r.fsm = XMP_ST_IDLE;
      end
    endcase

    // Pin drive follows the coming phase
    // claim only while off-chip phase runs
    claim = next_r.fsm inside {XMP_ST_SETUP, XMP_ST_ALE_HI,
                               XMP_ST_ALE_LO, XMP_ST_STROBE,
                               XMP_ST_HOLD};
    next_r.pins = xmp_idle_pins();
    if (claim) begin
      next_r.pins.rd_n_oe = 1'b1;
      next_r.pins.wr_n_oe = 1'b1;
      // only the matching strobe goes low
      next_r.pins.rd_n_out = ~(next_r.fsm == XMP_ST_STROBE
                               && !next_r.write);
      next_r.pins.wr_n_out = ~(next_r.fsm == XMP_ST_STROBE
                               && next_r.write);
      // short access outside mode 10 leaves high pins to latches
      next_r.pins.ahi_out = next_r.addr[15:8];
      next_r.pins.ahi_oe = next_r.hi_drive;
      if (mux) begin
        next_r.pins.ale_oe = 1'b1;
        next_r.pins.ale_out = next_r.fsm == XMP_ST_ALE_HI;
        if (next_r.fsm inside {XMP_ST_ALE_HI, XMP_ST_ALE_LO}) begin
          next_r.pins.ad_out = next_r.addr[7:0];
          next_r.pins.ad_oe = 8'hFF;
        end else if (next_r.write) begin
          next_r.pins.ad_out = next_r.wdata;
          next_r.pins.ad_oe = 8'hFF;
        end
      end else begin
        next_r.pins.alo_out = next_r.addr[7:0];
        next_r.pins.alo_oe = 1'b1;
        if (next_r.write) begin
          next_r.pins.ad_out = next_r.wdata;
          next_r.pins.ad_oe = 8'hFF;
        end
      end
      // data pins stay off during reads, except in the multiplexed address phases
      if (!next_r.write && !(mux && next_r.fsm inside
          {XMP_ST_ALE_HI, XMP_ST_ALE_LO})) begin
        next_r.pins.ad_oe = 8'h00;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.fsm <= XMP_ST_IDLE;
      r.page <= XMP_PAGE_RESET;
      r.cfg <= XMP_CFG_RESET;
      r.pins.rd_n_out <= 1'b1;
      r.pins.wr_n_out <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // no output-mode control leaves this block
  assign pins = r.pins;
  assign sfr_rdata = r.sfr_rdata;
  assign busy = r.fsm != XMP_ST_IDLE;
  assign done = r.done;
  assign rdata = r.rdata;
  assign onchip_sel = r.onchip_sel;
  assign onchip_write = r.write;
  assign onchip_addr = r.addr[9:0];
  assign onchip_wdata = r.wdata;

endmodule

// ==== verif/xmp_port_monitor.sv ====
// Checker for pin claiming, addressing and register reads
`timescale 1ns/10ps
module xmp_port_monitor
  import xmp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire xmp_sfr_t sfr,
  input wire logic [7:0] sfr_rdata,
  input wire xmp_req_t req,
  input wire logic busy,
  input wire logic onchip_sel,
  input wire logic [9:0] onchip_addr,
  input wire xmp_pins_t pins
);
  logic [7:0] cfg, pg, erd, acnt;
  logic [15:0] ea;
  logic wd, on;
  wire tk = req.valid && !busy;
  wire [15:0] ein = req.wide ? req.data_pointer : {pg, req.ri};
  wire ion = cfg[3:2] == 2'h0 || (cfg[3:2] != 2'h3 && ein < 16'h0400);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= 8'h03;
      pg <= 8'h00;
      erd <= 8'h00;
      acnt <= 8'h00;
      ea <= 16'h0000;
      wd <= 1'b0;
      on <= 1'b0;
    end else begin
      if (sfr.wr && sfr.addr == XMP_CFG_ADDR) cfg <= sfr.wdata & 8'h1F;
      if (sfr.wr && sfr.addr == XMP_PAGE_ADDR) pg <= sfr.wdata;
      erd <= !sfr.rd ? 8'h00 : sfr.addr == XMP_CFG_ADDR ? cfg :
        sfr.addr == XMP_PAGE_ADDR ? pg : 8'h00;
      acnt <= pins.ale_out ? acnt + 8'h01 : 8'h00;
      if (tk) begin
        ea <= ein;
        wd <= req.wide;
        on <= ion;
      end
    end
  end
  property p_claim;
    !busy || on |-> pins.ad_oe == 8'h00 && !pins.alo_oe && !pins.ahi_oe
      && !pins.ale_oe && !pins.rd_n_oe && !pins.wr_n_oe;
  endproperty
  a_claim: assert property (p_claim) else $error("pins claimed");
  property p_rdin; !pins.rd_n_out |-> pins.ad_oe == 8'h00; endproperty
  a_rdin: assert property (p_rdin) else $error("data driven");
  property p_wr;
    !pins.wr_n_out |-> pins.rd_n_out && pins.ad_oe == 8'hFF;
  endproperty
  a_wr: assert property (p_wr) else $error("strobe clash");
  property p_ale;
    $fell(pins.ale_out) |-> acnt == {6'h00, cfg[1:0]} + 8'h01;
  endproperty
  a_ale: assert property (p_ale) else $error("latch width");
  property p_lo;
    pins.alo_oe || pins.ale_out |-> cfg[4] == pins.alo_oe &&
      (pins.alo_oe ? pins.alo_out : pins.ad_out) == ea[7:0];
  endproperty
  a_lo: assert property (p_lo) else $error("low address");
  property p_hi;
    pins.ahi_oe |-> (wd || cfg[3:2] == 2'h2) && pins.ahi_out == ea[15:8];
  endproperty
  a_hi: assert property (p_hi) else $error("high address");
  property p_route;
    tk |=> onchip_sel == on && (!on || onchip_addr == ea[9:0]);
  endproperty
  a_route: assert property (p_route) else $error("routing");
  property p_rdata; sfr_rdata == erd; endproperty
  a_rdata: assert property (p_rdata) else $error("reg read");
  c_ale: cover property ($fell(pins.ale_out));
  c_on: cover property (onchip_sel);
  c_rd: cover property ($rose(pins.rd_n_out));
endmodule

bind xmp_port xmp_port_monitor xmp_port_monitor_inst (.ref_clk, .resetn,
  .sfr, .sfr_rdata, .req, .busy, .onchip_sel, .onchip_addr, .pins);

// ==== verif/xmp_sram_model.sv ====
// Off-chip memory with address latch behind the port pins
`timescale 1ns/10ps
module xmp_sram_model
  import xmp_pkg::*;
#(parameter int DLY = 20)
(
  input wire xmp_pins_t pins,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat = 8'h00;
  logic [7:0] rv;
  logic [15:0] addr;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(pins.ale_out or pins.ad_out) if (pins.ale_out) lat = pins.ad_out;
  assign addr = {pins.ahi_oe ? pins.ahi_out : 8'hFF,
    pins.alo_oe ? pins.alo_out : lat};
  always @(posedge pins.wr_n_out) if (pins.wr_n_oe) mem[addr] = pins.ad_out;
  always @* rv = |pins.ad_oe ? pins.ad_out :
    pins.rd_n_out ? 8'hFF : mem[addr];
  assign #DLY ad_in = rv;
endmodule

// ==== verif/test_xmp_port.sv ====
// Self-checking bench for the external memory port
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module test_xmp_port
  import xmp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  xmp_sfr_t sfr = '0;
  xmp_req_t req = '0;
  logic [7:0] onchip_rdata;
  logic [7:0] sfr_rdata, rdata, ad_in, onchip_wdata, q, pg, cfg, d;
  logic busy, done, onchip_sel, onchip_write, w, wd, on;
  logic [9:0] onchip_addr;
  logic [15:0] a;
  logic [16:0] p;
  logic [31:0] r;
  xmp_pins_t pins;
  logic [7:0] ram [0:1023];
  logic [7:0] img [0:131071];
  logic [7:0] his [8] = '{8'h00, 8'h03, 8'h04, 8'h12, 8'hFF, 8'h04, 8'h03,
    8'hFF};
  int seed = 55, n, mismatches = 0, checked = 0;
  xmp_port xmp_port_inst (.ref_clk, .resetn, .sfr, .sfr_rdata, .req, .busy,
    .done, .rdata, .onchip_sel, .onchip_write, .onchip_addr, .onchip_wdata,
    .onchip_rdata, .ad_in, .pins);
  xmp_sram_model xmp_sram_model_inst (.pins, .ad_in);
  initial forever #50 ref_clk = ~ref_clk;
  // On-chip RAM reads through
  assign onchip_rdata = ram[onchip_addr];
  always @(posedge ref_clk) begin
    if (onchip_sel && onchip_write) ram[onchip_addr] <= onchip_wdata;
  end
  function automatic logic [16:0] phys(logic f, logic [15:0] e,
    logic [1:0] m);
    if (m == 2'h0 || (m != 2'h3 && e < 16'h0400)) return {7'h00, e[9:0]};
    return {1'b1, f || m == 2'h2 ? e[15:8] : 8'hFF, e[7:0]};
  endfunction
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic sreg(input logic rd, input logic [7:0] ad, dt);
    @(posedge ref_clk);
    sfr <= '{!rd, rd, ad, dt};
    @(posedge ref_clk);
    sfr <= '0;
  endtask
  task automatic rchk(input logic [7:0] ad, e);
    sreg(1'b1, ad, 8'h00);
    @(negedge ref_clk);
    `CHK(sfr_rdata, e)
  endtask
  task automatic op();
    @(posedge ref_clk);
    req <= '{1'b1, w, wd, a, a[7:0], d};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    n = 0;
    on = 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
      on |= onchip_sel;
    end while (done !== 1'b1 && n < 40);
    if (n > 39) begin
      mismatches++;
      end_of_test();
    end
    q = rdata;
    p = phys(wd, a, cfg[3:2]);
    `CHK(on, !p[16])
    `CHK(n, p[16] ? (cfg[4] ? 7 : 2 * cfg[1:0] + 8) : 2)
    if (w) img[p] = d;
    else `CHK(q, img[p])
  endtask
  initial begin
    for (int i = 0; i < 131072; i++) img[i] = 8'(i) ^ 8'h5A;
    for (int i = 0; i < 1024; i++) ram[i] = 8'(i) ^ 8'h5A;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk(XMP_PAGE_ADDR, 8'h00);
    rchk(XMP_CFG_ADDR, 8'h03);
    rchk(8'h55, 8'h00);
    sreg(1'b0, XMP_CFG_ADDR, 8'hF4);
    rchk(XMP_CFG_ADDR, 8'h14);
    cfg = 8'h14;
    wd = 1'b1;
    for (int j = 0; j < 4; j++) begin
      w = !j[1];
      a = j[0] ? 16'h0400 : 16'h03FF;
      d = 8'hC3 ^ 8'(j);
      op();
    end
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      cfg = r[7:0];
      pg = his[r[10:8]];
      sreg(1'b0, XMP_CFG_ADDR, cfg);
      sreg(1'b0, XMP_PAGE_ADDR, pg);
      cfg &= 8'h1F;
      repeat (6) begin
        r = $random(seed);
        w = r[8];
        wd = r[9];
        a = {wd ? his[r[12:10]] : pg, r[3] ? {8{r[4]}} : {5'h00, r[2:0]}};
        d = r[23:16];
        op();
      end
    end
    end_of_test();
  end
endmodule
